// ==== design/pgs_pkg.sv ====
package pgs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PGS_ADDR_SOURCE_ASSIGN = 8'h16;
  localparam logic [7:0] PGS_ADDR_GATING_SELECT = 8'h17;
  localparam logic [7:0] PGS_ADDR_DELAY_VOLTAGE = 8'h18;
  localparam logic [7:0] PGS_ADDR_BUCK_SLOTS    = 8'h19;
  localparam logic [7:0] PGS_ADDR_LINREG_SLOTS  = 8'h1b;
  localparam logic [7:0] PGS_ADDR_BUCK1_NORMAL  = 8'h20;
  localparam logic [7:0] PGS_ADDR_BUCK1_ALT     = 8'h21;
  localparam logic [7:0] PGS_ADDR_BUCK2_NORMAL  = 8'h22;
  localparam logic [7:0] PGS_ADDR_BUCK2_ALT     = 8'h23;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks (spare bits read as zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] PGS_RST_SOURCE_ASSIGN  = 8'h42;
  localparam logic [7:0] PGS_RST_GATING_SELECT  = 8'h02;
  localparam logic [7:0] PGS_RST_DELAY_VOLTAGE  = 8'h00;
  localparam logic [7:0] PGS_MASK_SOURCE_ASSIGN = 8'h7f;
  localparam logic [7:0] PGS_MASK_GATING_SELECT = 8'h33;
  localparam logic [7:0] PGS_MASK_DELAY_VOLTAGE = 8'hdf;
  localparam logic [7:0] PGS_MASK_SLOTS         = 8'h3f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PGS_BIT_BUCK1_PG_ROUTE      = 0;
  localparam int PGS_BIT_BUCK2_PG_ROUTE      = 1;
  localparam int PGS_BIT_BUCK1_SCALING_ROUTE = 2;
  localparam int PGS_BIT_BUCK2_SCALING_ROUTE = 3;
  localparam int PGS_BIT_LINREG3_PG_ROUTE    = 4;
  localparam int PGS_BIT_LINREG4_PG_ROUTE    = 5;
  localparam int PGS_BIT_INTERNAL_RST_ROUTE  = 6;
  localparam int PGS_BIT_BUCK1_PG_GATE       = 0;
  localparam int PGS_BIT_BUCK2_PG_GATE       = 1;
  localparam int PGS_BIT_LINREG3_PG_GATE     = 4;
  localparam int PGS_BIT_LINREG4_PG_GATE     = 5;
  localparam int PGS_LSB_RELEASE_DELAY       = 0;
  localparam int PGS_LSB_SCALING_TIMING      = 3;
  localparam int PGS_BIT_BUCK1_VOLT_SELECT   = 6;
  localparam int PGS_BIT_BUCK2_VOLT_SELECT   = 7;
  localparam int PGS_LSB_SLOT_LOW            = 0;
  localparam int PGS_LSB_SLOT_HIGH           = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PGS_CLOCK_PERIOD_NS = 10;
  localparam int PGS_MS_NS           = 1000000;
  localparam int PGS_MS_CYCLES       = PGS_MS_NS / PGS_CLOCK_PERIOD_NS;
  localparam int PGS_STEP0_NS        = 1330;
  localparam int PGS_STEP1_NS        = 2670;
  localparam int PGS_STEP2_NS        = 5330;
  localparam int PGS_STEP3_NS        = 10670;
  localparam logic [10:0] PGS_STEP0_CYCLES = 11'(PGS_STEP0_NS / PGS_CLOCK_PERIOD_NS);
  localparam logic [10:0] PGS_STEP1_CYCLES = 11'(PGS_STEP1_NS / PGS_CLOCK_PERIOD_NS);
  localparam logic [10:0] PGS_STEP2_CYCLES = 11'(PGS_STEP2_NS / PGS_CLOCK_PERIOD_NS);
  localparam logic [10:0] PGS_STEP3_CYCLES = 11'(PGS_STEP3_NS / PGS_CLOCK_PERIOD_NS);

  // Power-good pin states, Gray along low -> wait -> high
  typedef enum logic [1:0] {
    PGS_LOW  = 2'b00,
    PGS_WAIT = 2'b01,
    PGS_HIGH = 2'b11
  } pgs_state_type;

endpackage

// ==== design/pgs_power_good_seq.sv ====
`timescale 1ns/1ps
// Functional notes
// RULE1 - Buck route bit set: that buck's power-good joins the power-good pin.
// RULE2 - Buck scaling route bit set: its voltage transition status drives the pin.
// RULE3 - Linear regulator route bit set: its power-good joins the pin.
// RULE4 - Reset route bit set: internal reset holds the pin low.
// RULE5 - Buck gate bit set: buck must be enabled for the pin to rise.
// RULE6 - Linear regulator gate bit set: regulator must be enabled for pin.
// RULE7 - Release delay code 0..7 gives 0, 8, 16, ... 512 ms.
// RULE8 - Scaling timing code gives 1.33, 2.67, 5.33 or 10.67 us steps.
// RULE9 - Buck1 select bit picks normal (0) or alternate (1) voltage code.
// RULE10 - Buck2 select bit picks normal (0) or alternate (1) voltage code.
// RULE11 - Each rail has a 3-bit start-up slot T0..T7.
// RULE12 - Pin rises only when all sources good, gated rails on, delay passed.
module pgs_power_good_seq
  import pgs_pkg::*;
#(
  parameter int         MS_CYCLES    = PGS_MS_CYCLES,
  parameter logic [7:0] BUCK_SLOTS   = 8'h01,
  parameter logic [7:0] LINREG_SLOTS = 8'h23,
  parameter logic [7:0] VOLT_DEFAULT = 8'h20
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Register port from the serial interface engine
  input  wire logic       i_reg_write,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // Rail status from the analogue side
  input  wire logic [1:0] i_buck_pg,
  input  wire logic [1:0] i_buck_scaling_busy,
  input  wire logic [1:0] i_linreg_pg,
  input  wire logic [1:0] i_buck_enabled,
  input  wire logic [1:0] i_linreg_enabled,
  input  wire logic       i_internal_reset,
  // Power-good pin and scaling timebase
  output logic            o_power_good_pin,
  output logic            o_scaling_step,
  // Voltage codes and start-up slots to the converters
  output logic      [7:0] o_buck1_voltage_code,
  output logic      [7:0] o_buck2_voltage_code,
  output logic      [2:0] o_buck1_start_slot,
  output logic      [2:0] o_buck2_start_slot,
  output logic      [2:0] o_linreg3_start_slot,
  output logic      [2:0] o_linreg4_start_slot
);

  localparam int MSW = $clog2(MS_CYCLES + 1);

  // ----------------------------------------------------------------
  // Release delay decode
  // ----------------------------------------------------------------
  function automatic logic [9:0] delay_ms(input logic [2:0] code);
    delay_ms = (code == 3'h0) ? 10'h000 : 10'(10'h004 << code);  // see RULE7
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] src_r, src_nxt, gate_r, gate_nxt, dly_r, dly_nxt;
  logic [7:0] bslot_r, bslot_nxt, lslot_r, lslot_nxt;
  logic [7:0] v1n_r, v1n_nxt, v1a_r, v1a_nxt, v2n_r, v2n_nxt, v2a_r, v2a_nxt;
  logic [7:0] rdata_nxt;

  // Writes land only in implemented bits; reads return the same masked view
  always_comb begin
    src_nxt   = src_r;
    gate_nxt  = gate_r;
    dly_nxt   = dly_r;
    bslot_nxt = bslot_r;
    lslot_nxt = lslot_r;
    v1n_nxt   = v1n_r;
    v1a_nxt   = v1a_r;
    v2n_nxt   = v2n_r;
    v2a_nxt   = v2a_r;
    if (i_reg_write) begin
      unique case (i_reg_addr)
        PGS_ADDR_SOURCE_ASSIGN: src_nxt   = i_reg_wdata & PGS_MASK_SOURCE_ASSIGN;
        PGS_ADDR_GATING_SELECT: gate_nxt  = i_reg_wdata & PGS_MASK_GATING_SELECT;
        PGS_ADDR_DELAY_VOLTAGE: dly_nxt   = i_reg_wdata & PGS_MASK_DELAY_VOLTAGE;
        PGS_ADDR_BUCK_SLOTS:    bslot_nxt = i_reg_wdata & PGS_MASK_SLOTS;      // see RULE11
        PGS_ADDR_LINREG_SLOTS:  lslot_nxt = i_reg_wdata & PGS_MASK_SLOTS;      // see RULE11
        PGS_ADDR_BUCK1_NORMAL:  v1n_nxt   = i_reg_wdata;
        PGS_ADDR_BUCK1_ALT:     v1a_nxt   = i_reg_wdata;
        PGS_ADDR_BUCK2_NORMAL:  v2n_nxt   = i_reg_wdata;
        PGS_ADDR_BUCK2_ALT:     v2a_nxt   = i_reg_wdata;
        default: ;
      endcase
    end
    unique case (i_reg_addr)
      PGS_ADDR_SOURCE_ASSIGN: rdata_nxt = src_r;
      PGS_ADDR_GATING_SELECT: rdata_nxt = gate_r;
      PGS_ADDR_DELAY_VOLTAGE: rdata_nxt = dly_r;
      PGS_ADDR_BUCK_SLOTS:    rdata_nxt = bslot_r;
      PGS_ADDR_LINREG_SLOTS:  rdata_nxt = lslot_r;
      PGS_ADDR_BUCK1_NORMAL:  rdata_nxt = v1n_r;
      PGS_ADDR_BUCK1_ALT:     rdata_nxt = v1a_r;
      PGS_ADDR_BUCK2_NORMAL:  rdata_nxt = v2n_r;
      PGS_ADDR_BUCK2_ALT:     rdata_nxt = v2a_r;
      default:                rdata_nxt = 8'h00;  // Unmapped reads as zero
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_r       <= PGS_RST_SOURCE_ASSIGN;
      gate_r      <= PGS_RST_GATING_SELECT;
      dly_r       <= PGS_RST_DELAY_VOLTAGE;
      bslot_r     <= BUCK_SLOTS & PGS_MASK_SLOTS;
      lslot_r     <= LINREG_SLOTS & PGS_MASK_SLOTS;
      v1n_r       <= VOLT_DEFAULT;
      v1a_r       <= VOLT_DEFAULT;
      v2n_r       <= VOLT_DEFAULT;
      v2a_r       <= VOLT_DEFAULT;
      o_reg_rdata <= 8'h00;
    end else begin
      src_r       <= src_nxt;
      gate_r      <= gate_nxt;
      dly_r       <= dly_nxt;
      bslot_r     <= bslot_nxt;
      lslot_r     <= lslot_nxt;
      v1n_r       <= v1n_nxt;
      v1a_r       <= v1a_nxt;
      v2n_r       <= v2n_nxt;
      v2a_r       <= v2a_nxt;
      o_reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status synchronisers
  // ----------------------------------------------------------------
  // Analogue comparators are asynchronous to the clock
  logic [10:0] stat_meta_r, stat_sync_r;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_meta_r <= 11'h000;
      stat_sync_r <= 11'h000;
    end else begin
      stat_meta_r <= {i_internal_reset, i_linreg_enabled, i_buck_enabled,
                      i_linreg_pg, i_buck_scaling_busy, i_buck_pg};
      stat_sync_r <= stat_meta_r;
    end
  end

  logic [1:0] buck_pg_s, busy_s, lin_pg_s, buck_en_s, lin_en_s;
  logic       int_rst_s;
  assign {int_rst_s, lin_en_s, buck_en_s, lin_pg_s, busy_s, buck_pg_s} = stat_sync_r;

  // ----------------------------------------------------------------
  // Power-good combine
  // ----------------------------------------------------------------
  // An unassigned or ungated source never blocks the pin
  logic raw_good;
  always_comb begin
    raw_good = 1'b1;
    if (src_r[PGS_BIT_BUCK1_PG_ROUTE]      && !buck_pg_s[0]) raw_good = 1'b0;  // see RULE1
    if (src_r[PGS_BIT_BUCK2_PG_ROUTE]      && !buck_pg_s[1]) raw_good = 1'b0;  // see RULE1
    if (src_r[PGS_BIT_BUCK1_SCALING_ROUTE] &&  busy_s[0])    raw_good = 1'b0;  // see RULE2
    if (src_r[PGS_BIT_BUCK2_SCALING_ROUTE] &&  busy_s[1])    raw_good = 1'b0;  // see RULE2
    if (src_r[PGS_BIT_LINREG3_PG_ROUTE]    && !lin_pg_s[0])  raw_good = 1'b0;  // see RULE3
    if (src_r[PGS_BIT_LINREG4_PG_ROUTE]    && !lin_pg_s[1])  raw_good = 1'b0;  // see RULE3
    if (src_r[PGS_BIT_INTERNAL_RST_ROUTE]  &&  int_rst_s)    raw_good = 1'b0;  // see RULE4
    if (gate_r[PGS_BIT_BUCK1_PG_GATE]      && !buck_en_s[0]) raw_good = 1'b0;  // see RULE5
    if (gate_r[PGS_BIT_BUCK2_PG_GATE]      && !buck_en_s[1]) raw_good = 1'b0;  // see RULE5
    if (gate_r[PGS_BIT_LINREG3_PG_GATE]    && !lin_en_s[0])  raw_good = 1'b0;  // see RULE6
    if (gate_r[PGS_BIT_LINREG4_PG_GATE]    && !lin_en_s[1])  raw_good = 1'b0;  // see RULE6
  end

  // ----------------------------------------------------------------
  // Release delay state machine
  // ----------------------------------------------------------------
  pgs_state_type state_r, state_nxt;
  logic [MSW-1:0] pre_r, pre_nxt;
  logic [9:0]     ms_r, ms_nxt;
  logic [9:0]     target;
  logic           pin_nxt;

  // Delay restarts from zero on any loss of good, so glitches never shorten it
  always_comb begin
    target    = delay_ms(dly_r[PGS_LSB_RELEASE_DELAY +: 3]);  // see RULE7
    state_nxt = state_r;
    pre_nxt   = '0;
    ms_nxt    = 10'h000;
    unique case (state_r)
      PGS_LOW: begin
        if (raw_good) state_nxt = (target == 10'h000) ? PGS_HIGH : PGS_WAIT;
      end
      PGS_WAIT: begin
        if (!raw_good) begin
          state_nxt = PGS_LOW;
        end else if (ms_r == target) begin
          state_nxt = PGS_HIGH;  // see RULE12
        end else if (pre_r == MSW'(MS_CYCLES - 1)) begin
          ms_nxt = 10'(ms_r + 10'h001);
        end else begin
          pre_nxt = MSW'(pre_r + 1'b1);
          ms_nxt  = ms_r;
        end
      end
      PGS_HIGH: begin
        if (!raw_good) state_nxt = PGS_LOW;  // see RULE12
      end
      default: state_nxt = PGS_LOW;
    endcase
    pin_nxt = (state_nxt == PGS_HIGH);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r          <= PGS_LOW;
      pre_r            <= '0;
      ms_r             <= 10'h000;
      o_power_good_pin <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      pre_r            <= pre_nxt;
      ms_r             <= ms_nxt;
      o_power_good_pin <= pin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Scaling step timebase
  // ----------------------------------------------------------------
  logic [10:0] step_r, step_nxt, step_len;
  logic        tick_nxt;
  always_comb begin
    unique case (dly_r[PGS_LSB_SCALING_TIMING +: 2])  // see RULE8
      2'b00: step_len = PGS_STEP0_CYCLES;
      2'b01: step_len = PGS_STEP1_CYCLES;
      2'b10: step_len = PGS_STEP2_CYCLES;
      2'b11: step_len = PGS_STEP3_CYCLES;
    endcase
    // Compare with >= so a shorter new setting cannot strand the counter
    tick_nxt = (step_r >= 11'(step_len - 11'h001));
    step_nxt = tick_nxt ? 11'h000 : 11'(step_r + 11'h001);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_r         <= 11'h000;
      o_scaling_step <= 1'b0;
    end else begin
      step_r         <= step_nxt;
      o_scaling_step <= tick_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Voltage code select and start slots
  // ----------------------------------------------------------------
  logic [7:0] code1_nxt, code2_nxt;
  always_comb begin
    code1_nxt = dly_r[PGS_BIT_BUCK1_VOLT_SELECT] ? v1a_r : v1n_r;  // see RULE9
    code2_nxt = dly_r[PGS_BIT_BUCK2_VOLT_SELECT] ? v2a_r : v2n_r;  // see RULE10
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_buck1_voltage_code <= 8'h00;
      o_buck2_voltage_code <= 8'h00;
    end else begin
      o_buck1_voltage_code <= code1_nxt;
      o_buck2_voltage_code <= code2_nxt;
    end
  end

  // Slots come straight from flip-flops of the slot registers
  assign o_buck1_start_slot   = bslot_r[PGS_LSB_SLOT_LOW +: 3];   // see RULE11
  assign o_buck2_start_slot   = bslot_r[PGS_LSB_SLOT_HIGH +: 3];  // see RULE11
  assign o_linreg3_start_slot = lslot_r[PGS_LSB_SLOT_LOW +: 3];   // see RULE11
  assign o_linreg4_start_slot = lslot_r[PGS_LSB_SLOT_HIGH +: 3];  // see RULE11

endmodule

// ==== testbench/pgs_host_watch.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Host processor watching the pin
// ----------------------------------------
module pgs_host_watch (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // Pin and release count
  input  wire logic i_power_good_pin,
  output int        o_rises
);
  logic pin_q_r;

  // A glitch during the wait shows up as an extra release
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q_r <= 1'b0;
      o_rises <= 0;
    end else begin
      pin_q_r <= i_power_good_pin;
      if (i_power_good_pin && !pin_q_r) o_rises <= o_rises + 1;
    end
  end
endmodule

// ==== testbench/pgs_power_good_seq_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Power-good pin and register port checker
// ----------------------------------------
module pgs_power_good_seq_monitor
  import pgs_pkg::*;
#(
  parameter int MS_CYCLES = PGS_MS_CYCLES
) (
  // Clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  // Register port
  input wire logic       i_reg_write,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Rail status
  input wire logic [1:0] i_buck_pg,
  input wire logic [1:0] i_buck_scaling_busy,
  input wire logic [1:0] i_linreg_pg,
  input wire logic [1:0] i_buck_enabled,
  input wire logic [1:0] i_linreg_enabled,
  input wire logic       i_internal_reset,
  // Pin and timebase
  input wire logic       o_power_good_pin,
  input wire logic       o_scaling_step
);
  logic [7:0]  src_r, src_nxt, gate_r, gate_nxt;
  logic [2:0]  dly_r, dly_nxt;
  logic [15:0] cnt_r, cnt_nxt, n, lim, hi;
  logic        ok;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // Shadow fields; ok uses live inputs, so the bounds carry slack for the sync stages
  always_comb begin
    src_nxt  = src_r;
    gate_nxt = gate_r;
    dly_nxt  = dly_r;
    if (i_reg_write && i_reg_addr == 8'h16) src_nxt = i_reg_wdata;
    if (i_reg_write && i_reg_addr == 8'h17) gate_nxt = i_reg_wdata;
    if (i_reg_write && i_reg_addr == 8'h18) dly_nxt = i_reg_wdata[2:0];
    ok  = ~|{src_r[1:0] & ~i_buck_pg, src_r[3:2] & i_buck_scaling_busy, src_r[5:4] & ~i_linreg_pg,
             src_r[6] & i_internal_reset, gate_r[1:0] & ~i_buck_enabled, gate_r[5:4] & ~i_linreg_enabled};
    n   = (dly_r == 3'h0) ? 16'h0000 : (16'h0004 << dly_r);
    lim = 16'(n * MS_CYCLES);
    hi  = lim + (n << 1) + 16'h0008;
    cnt_nxt = ok ? ((cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h0001) : 16'h0000;
  end

  // Register the shadows and the good-run counter
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_r  <= 8'h42;
      gate_r <= 8'h02;
      dly_r  <= 3'h0;
      cnt_r  <= 16'h0000;
    end else begin
      src_r  <= src_nxt;
      gate_r <= gate_nxt;
      dly_r  <= dly_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  property p_step_gap; o_scaling_step |=> !o_scaling_step [*8]; endproperty
  property p_reset_quiet; $rose(i_rst_n) |-> !o_power_good_pin && !o_scaling_step; endproperty
  property p_bad_low; (!ok) [*4] |=> !o_power_good_pin; endproperty
  property p_rst_low; (src_r[6] && i_internal_reset) [*4] |=> !o_power_good_pin; endproperty
  property p_dly_min; $rose(o_power_good_pin) |-> cnt_r >= lim; endproperty
  property p_dly_max; cnt_r == hi |-> o_power_good_pin; endproperty
  property p_rd_src; i_reg_addr == 8'h16 |=> o_reg_rdata == ($past(src_r) & 8'h7f); endproperty
  property p_rd_gate; i_reg_addr == 8'h17 |=> o_reg_rdata == ($past(gate_r) & 8'h33); endproperty
  property p_rd_unmapped;
    !(i_reg_addr inside {8'h16, 8'h17, 8'h18, 8'h19, 8'h1b, [8'h20:8'h23]}) |=> o_reg_rdata == 8'h00;
  endproperty

  a_step_gap: assert property (p_step_gap) else $error("step pulses too close");
  a_reset_quiet: assert property (p_reset_quiet) else $error("pin active at reset release");
  a_bad_low: assert property (p_bad_low) else $error("pin high with a bad source");
  a_rst_low: assert property (p_rst_low) else $error("pin high in internal reset");
  a_dly_min: assert property (p_dly_min) else $error("pin released early");
  a_dly_max: assert property (p_dly_max) else $error("pin released late");
  a_rd_src: assert property (p_rd_src) else $error("routing readback wrong");
  a_rd_gate: assert property (p_rd_gate) else $error("gating readback wrong");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  c_release: cover property ($rose(o_power_good_pin) && dly_r != 3'h0);
  c_step: cover property (o_scaling_step);
  c_unmapped: cover property (i_reg_addr == 8'h1a);
endmodule

bind pgs_power_good_seq pgs_power_good_seq_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .i_clock, .i_rst_n, .i_reg_write, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_buck_pg,
  .i_buck_scaling_busy, .i_linreg_pg, .i_buck_enabled, .i_linreg_enabled, .i_internal_reset,
  .o_power_good_pin, .o_scaling_step);

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb;
  localparam int         MS  = 10;
  localparam logic [7:0] BSL = 8'h01;
  localparam logic [7:0] LSL = 8'h23;
  localparam logic [7:0] VDF = 8'h20;
  logic        i_clock, i_rst_n, i_reg_write, i_internal_reset, o_power_good_pin, o_scaling_step;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_buck1_voltage_code, o_buck2_voltage_code;
  logic [1:0]  i_buck_pg, i_buck_scaling_busy, i_linreg_pg, i_buck_enabled, i_linreg_enabled;
  logic [2:0]  o_buck1_start_slot, o_buck2_start_slot, o_linreg3_start_slot, o_linreg4_start_slot;
  logic [10:0] flt;
  logic [7:0]  alist [12] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1b, 8'h20, 8'h21, 8'h22, 8'h23, 8'h10, 8'h1a, 8'h24};
  int          steps [4] = '{1330, 2670, 5330, 10670};
  int          mreg [256];
  int          rises, mismatches, checks_done, seed;

  // One fault bit per route or gate source
  assign i_buck_pg           = ~flt[1:0];
  assign i_buck_scaling_busy = flt[3:2];
  assign i_linreg_pg         = ~flt[5:4];
  assign i_internal_reset    = flt[6];
  assign i_buck_enabled      = ~flt[8:7];
  assign i_linreg_enabled    = ~flt[10:9];

  pgs_power_good_seq #(.MS_CYCLES(MS), .BUCK_SLOTS(BSL), .LINREG_SLOTS(LSL), .VOLT_DEFAULT(VDF)) u_dut (
    .i_clock, .i_rst_n, .i_reg_write, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_buck_pg,
    .i_buck_scaling_busy, .i_linreg_pg, .i_buck_enabled, .i_linreg_enabled, .i_internal_reset,
    .o_power_good_pin, .o_scaling_step, .o_buck1_voltage_code, .o_buck2_voltage_code,
    .o_buck1_start_slot, .o_buck2_start_slot, .o_linreg3_start_slot, .o_linreg4_start_slot);
  pgs_host_watch u_host (.i_clock, .i_rst_n, .i_power_good_pin(o_power_good_pin), .o_rises(rises));

  // Writable bits per offset; spare and unmapped bits read zero
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h16: return 8'h7f;
      8'h17: return 8'h33;
      8'h18: return 8'hdf;
      8'h19, 8'h1b: return 8'h3f;
      8'h20, 8'h21, 8'h22, 8'h23: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Entered and left 1 ns after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_write = 1'b1;
    @(posedge i_clock);
    #1;
    i_reg_write = 1'b0;
    mreg[a] = d & msk(a);
    // Idle edge, so a following write never raises the strobe in this time step
    @(posedge i_clock);
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    i_reg_addr = a;
    @(posedge i_clock);
    #1;
    chk("register read", o_reg_rdata, mreg[a][7:0]);
  endtask

  // Six edges leaves slack over the three-edge path of a zero delay
  task automatic pin_case(input logic [7:0] s, input logic [7:0] g, input logic [10:0] f);
    logic [10:0] en;
    wr(8'h16, s);
    wr(8'h17, g);
    flt = f;
    repeat (6) @(posedge i_clock);
    #1;
    en = {g[5:4], g[1:0], s[6:0]};
    chk("power good pin", o_power_good_pin, ~|(en & f));
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Whole run is near 15k cycles; this cuts a hang at 100k
  initial begin
    #1_000_000;
    mismatches++;
    complete_run();
  end

  initial begin
    int         n;
    logic [7:0] s8, g8;
    seed = 32'h1df1;
    i_rst_n = 1'b0;
    i_reg_write = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    flt = 11'h7ff;
    for (int a = 0; a < 256; a++) mreg[a] = (a >= 8'h20 && a <= 8'h23) ? VDF : 0;
    mreg[8'h16] = 8'h42;
    mreg[8'h17] = 8'h02;
    mreg[8'h19] = BSL & 8'h3f;
    mreg[8'h1b] = LSL & 8'h3f;
    repeat (3) @(posedge i_clock);
    #1;
    i_rst_n = 1'b1;
    // Defaults, then random writes; reset route stays set so no wait starts
    foreach (alist[i]) rd(alist[i]);
    foreach (alist[i]) begin
      s8 = 8'($random(seed));
      wr(alist[i], (alist[i] == 8'h16) ? (s8 | 8'h40) : s8);
      rd(alist[i]);
    end
    chk("buck1 slot", o_buck1_start_slot, mreg[8'h19][2:0]);
    chk("buck2 slot", o_buck2_start_slot, mreg[8'h19][5:3]);
    chk("linreg3 slot", o_linreg3_start_slot, mreg[8'h1b][2:0]);
    chk("linreg4 slot", o_linreg4_start_slot, mreg[8'h1b][5:3]);
    for (int s = 0; s < 4; s++) begin
      wr(8'h18, {s[1:0], 6'h00});
      repeat (2) @(posedge i_clock);
      #1;
      chk("buck1 code", o_buck1_voltage_code, s[0] ? mreg[8'h21][7:0] : mreg[8'h20][7:0]);
      chk("buck2 code", o_buck2_voltage_code, s[1] ? mreg[8'h23][7:0] : mreg[8'h22][7:0]);
    end
    $display("registers test done");
    // Each source faulted alone, then with its own bit cleared
    for (int i = 0; i < 11; i++) begin
      pin_case(8'h7f, 8'h33, 11'h001 << i);
      s8 = 8'h7f;
      g8 = 8'h33;
      if (i < 7) s8[i] = 1'b0;
      else g8[(i < 9) ? i - 7 : i - 5] = 1'b0;
      pin_case(s8, g8, 11'h001 << i);
    end
    for (int i = 0; i < 30; i++) begin
      pin_case(8'($random(seed)), 8'($random(seed)),
               11'($random(seed) & $random(seed) & $random(seed)));
    end
    $display("routing test done");
    // Skip the first pulse after a code change, then time one period
    for (int c = 0; c < 4; c++) begin
      wr(8'h18, 8'(c << 3));
      for (int k = 0; k < 2; k++) begin
        n = 0;
        do begin
          @(posedge i_clock);
          #1;
          n++;
        end while (!o_scaling_step && n < 3000);
      end
      chk("step period", 16'(n), 16'(steps[c] / 10));
    end
    $display("step test done");
    // Delay code set while held in reset, so no wait is running
    for (int c = 1; c < 8; c++) begin
      pin_case(8'h7f, 8'h33, 11'h040);
      wr(8'h18, 8'(c));
      s8 = 8'(rises);
      flt = 11'h000;
      n = 0;
      do begin
        @(posedge i_clock);
        #1;
        n++;
      end while (o_power_good_pin !== 1'b1 && n < 8000);
      chk("release delay", 16'(n >= (4 << c) * MS && n <= (4 << c) * (MS + 2) + 8), 16'h0001);
      @(posedge i_clock);
      #1;
      chk("pin releases", 16'(8'(rises)), 16'(8'(s8 + 8'h01)));
    end
    $display("release delay test done");
    complete_run();
  end
endmodule
